// [logic/ctk_defs.svh]
`ifndef CTK_DEFS_SVH
`define CTK_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets on the special function register port
// ----------------------------------------------------------------
`define CTK_OFS_OPTION 8'h94
`define CTK_OFS_INTERRUPT_FLAG_REG 8'h95
`define CTK_OFS_SHDATA 8'hAA
`define CTK_OFS_CNTLOW 8'hAC
`define CTK_OFS_TCTRL 8'hAD
`define CTK_OFS_CHSEL 8'hA7
`define CTK_OFS_AUX_CONTROL_ONE 8'hF8

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTK_BIT_FREQHOP 6
`define CTK_BIT_IRQFLAG 5
`define CTK_BIT_START 5
`define CTK_BIT_PDOWN 7
`define CTK_BIT_DONE 6
`define CTK_BIT_SLOW 5
`define CTK_POS_VSEL 3
`define CTK_POS_TSEL 0
`define CTK_POS_TRIM 5
`define CTK_POS_CHAN 0

// ----------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------
`define CTK_RST_PDOWN 1'b1
`define CTK_RST_DONE 1'b1
`define CTK_RST_SLOW 1'b0
`define CTK_RST_VSEL 2'h0
`define CTK_RST_TSEL 3'h4
`define CTK_RST_TRIM 3'h1
`define CTK_RST_CHAN 5'h1F
`define CTK_RST_HOP 1'b0
`define CTK_CHAN_LAST 5'h13
`define CTK_CHAN_REF 5'h17
`define CTK_CNT_MAX 12'hFFF

// ----------------------------------------------------------------
// Timing counts in reference clock cycles and touch ticks
// ----------------------------------------------------------------
`define CTK_SETTLE_CYC 4'h4
`define CTK_DIV_BASE 6'h08
`define CTK_WIN_BASE 16'h0040

`endif

// [logic/ctk_pkg.sv]
package ctk_pkg;
	typedef enum logic [1:0] {
		CTK_IDLE = 2'b00,
		CTK_SETTLE = 2'b01,
		CTK_RUN = 2'b10
	} ctk_state_e;
	typedef logic [11:0] ctk_count_t;
	typedef logic [4:0] ctk_chan_t;
endpackage

// [logic/ctk_meas_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ctk_meas_if;
	logic run;
	logic clear;
	logic [2:0] timeSel;
	logic freqHop;
	logic slowClk;
	logic [2:0] trim;
	logic tick;
	logic windowEnd;
	logic [11:0] count;
	modport seq (output run, clear, timeSel, freqHop, slowClk, trim, input tick, windowEnd, count);
	modport clk (input run, freqHop, slowClk, trim, output tick);
	modport cnt (input run, clear, timeSel, tick, output windowEnd, count);
endinterface
`default_nettype wire

// [logic/ctk_clk_gen.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctk_defs.svh"
module ctk_clk_gen (
	input wire logic ref_clk,
	input wire logic srst,
	ctk_meas_if.clk meas
);
	import ctk_pkg::*;
	logic [6:0] divCnt_reg;
	logic [2:0] hopLfsr_reg;
	logic halfTick_reg;
	logic [6:0] period;
	logic rawTick;

	// ----------------------------------------------------------------
	// Touch clock divider
	// ----------------------------------------------------------------
	// Trim 7 gives the shortest period; hopping replaces trim by an LFSR
	always_comb begin
		period = {1'b0, `CTK_DIV_BASE} + {4'h0, (meas.freqHop ? hopLfsr_reg : ~meas.trim)};
	end
	assign rawTick = meas.run && (divCnt_reg >= period);

	always_ff @(posedge ref_clk) begin
		if (srst || !meas.run || rawTick) begin
			divCnt_reg <= 7'h00;
		end else begin
			divCnt_reg <= divCnt_reg + 7'h01;
		end
	end

	// Hop sequence steps once per tick so every period is a full one
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			hopLfsr_reg <= 3'h1;
		end else if (rawTick && meas.freqHop) begin
			hopLfsr_reg <= {hopLfsr_reg[1:0], hopLfsr_reg[2] ^ hopLfsr_reg[1]};
		end
	end

	// Slow mode passes every second tick only
	always_ff @(posedge ref_clk) begin
		if (srst || !meas.run) begin
			halfTick_reg <= 1'b0;
		end else if (rawTick) begin
			halfTick_reg <= ~halfTick_reg;
		end
	end
	assign meas.tick = rawTick && (!meas.slowClk || halfTick_reg);
endmodule // ctk_clk_gen
`default_nettype wire

// [logic/ctk_counter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctk_defs.svh"
module ctk_counter (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic senseOsc,
	ctk_meas_if.cnt meas
);
	import ctk_pkg::*;
	logic [15:0] winCnt_reg;
	logic [11:0] count_reg;
	logic senseLast_reg;
	logic [15:0] winLen;

	// ----------------------------------------------------------------
	// Charging window and sense edge count
	// ----------------------------------------------------------------
	// Longer time setting doubles the window, so counts grow with it
	assign winLen = `CTK_WIN_BASE << meas.timeSel;
	assign meas.windowEnd = meas.run && meas.tick && (winCnt_reg == winLen - 16'h0001);
	assign meas.count = count_reg;

	always_ff @(posedge ref_clk) begin
		if (srst || meas.clear) begin
			winCnt_reg <= 16'h0000;
		end else if (meas.run && meas.tick) begin
			winCnt_reg <= winCnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			senseLast_reg <= 1'b0;
		end else begin
			senseLast_reg <= senseOsc;
		end
	end

	// Saturates rather than wraps so a huge key never looks small
	always_ff @(posedge ref_clk) begin
		if (srst || meas.clear) begin
			count_reg <= 12'h000;
		end else if (meas.run && senseOsc && !senseLast_reg && count_reg != `CTK_CNT_MAX) begin
			count_reg <= count_reg + 12'h001;
		end
	end
endmodule // ctk_counter
`default_nettype wire

// [logic/ctk_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ctk_defs.svh"
module ctk_sequencer #(
	parameter int NUM_CHAN = 20
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic sfrRdEn,
	output logic [7:0] sfrRdData,
	input wire logic senseOsc,
	output logic analogEnable,
	output logic [NUM_CHAN-1:0] padSelect,
	output logic refCapSelect,
	output logic [1:0] voltSelect,
	output logic touchClkTick,
	output logic convBusy,
	output logic touchIrqFlag
);
	import ctk_pkg::*;

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	// Measurement bundle and sequencer state
	ctk_meas_if meas ();
	ctk_state_e state_reg;
	ctk_state_e state_next;
	logic [3:0] settleCnt_reg;

	// Software visible fields
	logic powerDown_reg;
	logic done_reg;
	logic slowClk_reg;
	logic [1:0] voltSel_reg;
	logic [2:0] timeSel_reg;
	logic [2:0] trim_reg;
	ctk_chan_t chanSel_reg;
	logic freqHop_reg;
	logic start_reg;
	logic irqFlag_reg;
	ctk_count_t result_reg;
	logic [NUM_CHAN-1:0] padSel_reg;
	logic refSel_reg;
	logic [7:0] rdData_reg;

	// Decoded strobes and events
	logic wrOption;
	logic wrIntflg;
	logic wrTctrl;
	logic wrChsel;
	logic wrAux;
	logic startReq;
	logic stopReq;
	logic abortConv;
	logic convEnd;

	// ----------------------------------------------------------------
	// Address decode helper
	// ----------------------------------------------------------------
	// Shared by all write strobes so the compare is written once
	function automatic logic hitWr(input logic [7:0] addr, input logic [7:0] ofs,
		input logic en);
		hitWr = en && (addr == ofs);
	endfunction

	// Channel code to one-hot pad select; unused codes select nothing
	function automatic logic padHit(input ctk_chan_t code, input int idx);
		padHit = (code <= `CTK_CHAN_LAST) && (code == idx[4:0]);
	endfunction

	// ----------------------------------------------------------------
	// Write strobes
	// ----------------------------------------------------------------
	// One strobe per writable register; the result registers have none
	assign wrOption = hitWr(sfrAddr, `CTK_OFS_OPTION, sfrWrEn);
	assign wrIntflg = hitWr(sfrAddr, `CTK_OFS_INTERRUPT_FLAG_REG, sfrWrEn);
	assign wrTctrl = hitWr(sfrAddr, `CTK_OFS_TCTRL, sfrWrEn);
	assign wrChsel = hitWr(sfrAddr, `CTK_OFS_CHSEL, sfrWrEn);
	assign wrAux = hitWr(sfrAddr, `CTK_OFS_AUX_CONTROL_ONE, sfrWrEn);

	// Start only while powered up and idle; a start during a run is ignored
	assign startReq = wrAux && sfrWrData[`CTK_BIT_START] && !powerDown_reg
		&& (state_reg == CTK_IDLE);
	// Clearing the start bit by software drops a run in progress
	assign stopReq = wrAux && !sfrWrData[`CTK_BIT_START];
	// Powering down mid-run also drops the conversion, keeping old data
	assign abortConv = stopReq || (wrTctrl && sfrWrData[`CTK_BIT_PDOWN]);
	// An abort in the last window cycle wins over completion
	assign convEnd = (state_reg == CTK_RUN) && meas.windowEnd && !abortConv;

	// ----------------------------------------------------------------
	// Conversion sequencer
	// ----------------------------------------------------------------
	// Settle phase lets the pad mux and oscillator steady before counting
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CTK_IDLE: begin
				if (startReq) begin
					state_next = CTK_SETTLE;
				end
			end
			CTK_SETTLE: begin
				if (abortConv) begin
					state_next = CTK_IDLE;
				end else if (settleCnt_reg == `CTK_SETTLE_CYC - 4'h1) begin
					state_next = CTK_RUN;
				end
			end
			CTK_RUN: begin
				if (abortConv || meas.windowEnd) begin
					state_next = CTK_IDLE;
				end
			end
			// Unused state code falls back to idle
			default: begin
				state_next = CTK_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= CTK_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Counts settle cycles; held at zero outside settle
	always_ff @(posedge ref_clk) begin
		if (srst || state_reg != CTK_SETTLE) begin
			settleCnt_reg <= 4'h0;
		end else begin
			settleCnt_reg <= settleCnt_reg + 4'h1;
		end
	end

	// ----------------------------------------------------------------
	// Touch control register fields
	// ----------------------------------------------------------------
	// Done is read-only; a control write changes it only through a power-down abort
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			powerDown_reg <= `CTK_RST_PDOWN;
			slowClk_reg <= `CTK_RST_SLOW;
			voltSel_reg <= `CTK_RST_VSEL;
			timeSel_reg <= `CTK_RST_TSEL;
		end else if (wrTctrl) begin
			powerDown_reg <= sfrWrData[`CTK_BIT_PDOWN];
			slowClk_reg <= sfrWrData[`CTK_BIT_SLOW];
			voltSel_reg <= sfrWrData[`CTK_POS_VSEL +: 2];
			timeSel_reg <= sfrWrData[`CTK_POS_TSEL +: 3];
		end
	end

	// Done drops with the start and rises at the window end or an abort
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			done_reg <= `CTK_RST_DONE;
		end else if (startReq) begin
			done_reg <= 1'b0;
		end else if (convEnd || (state_reg != CTK_IDLE && abortConv)) begin
			done_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Channel select and option fields
	// ----------------------------------------------------------------
	// Trim shares the channel register, so both load together
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			chanSel_reg <= `CTK_RST_CHAN;
			trim_reg <= `CTK_RST_TRIM;
		end else if (wrChsel) begin
			chanSel_reg <= sfrWrData[`CTK_POS_CHAN +: 5];
			trim_reg <= sfrWrData[`CTK_POS_TRIM +: 3];
		end
	end

	// Only the hop bit of the option register lives here
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			freqHop_reg <= `CTK_RST_HOP;
		end else if (wrOption) begin
			freqHop_reg <= sfrWrData[`CTK_BIT_FREQHOP];
		end
	end

	// ----------------------------------------------------------------
	// Start bit
	// ----------------------------------------------------------------
	// A start written while a run is pending keeps the bit high
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			start_reg <= 1'b0;
		end else if (startReq) begin
			start_reg <= 1'b1;
		end else if (stopReq) begin
			start_reg <= 1'b0;
		end else if (convEnd) begin
			start_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Touch interrupt flag
	// ----------------------------------------------------------------
	// End of conversion wins over a same-cycle clear write
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irqFlag_reg <= 1'b0;
		end else if (convEnd) begin
			irqFlag_reg <= 1'b1;
		end else if (startReq || (wrIntflg && !sfrWrData[`CTK_BIT_IRQFLAG])) begin
			irqFlag_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Result capture
	// ----------------------------------------------------------------
	// Only a finished window updates the result, so reads never tear
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			result_reg <= 12'h000;
		end else if (convEnd) begin
			result_reg <= meas.count;
		end
	end

	// ----------------------------------------------------------------
	// Pad and reference capacitor selection
	// ----------------------------------------------------------------
	// Mux is held only during a conversion; idle pads stay free for GPIO
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CHAN; gi++) begin : g_pad
			always_ff @(posedge ref_clk) begin
				if (srst) begin
					padSel_reg[gi] <= 1'b0;
				end else begin
					padSel_reg[gi] <= (state_next != CTK_IDLE) && padHit(chanSel_reg, gi);
				end
			end
		end
	endgenerate

	// Reference capacitor stands in for the pads on code 17h
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			refSel_reg <= 1'b0;
		end else begin
			refSel_reg <= (state_next != CTK_IDLE) && (chanSel_reg == `CTK_CHAN_REF);
		end
	end

	// ----------------------------------------------------------------
	// Measurement submodules
	// ----------------------------------------------------------------
	// Run drops in the abort cycle so no late tick is counted
	assign meas.run = (state_reg == CTK_RUN) && !abortConv;
	assign meas.clear = (state_reg != CTK_RUN);
	assign meas.timeSel = timeSel_reg;
	assign meas.freqHop = freqHop_reg;
	assign meas.slowClk = slowClk_reg;
	assign meas.trim = trim_reg;

	// Touch clock derived from the system clock
	ctk_clk_gen u_clk_gen (
		.ref_clk(ref_clk),
		.srst(srst),
		.meas(meas)
	);

	// Window timer and sense edge counter
	ctk_counter u_counter (
		.ref_clk(ref_clk),
		.srst(srst),
		.senseOsc(senseOsc),
		.meas(meas)
	);

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	// Bits owned by other blocks in shared registers read as zero here
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdData_reg <= 8'h00;
		end else if (sfrRdEn) begin
			unique case (sfrAddr)
				`CTK_OFS_OPTION: rdData_reg <= {1'b0, freqHop_reg, 6'h00};
				`CTK_OFS_INTERRUPT_FLAG_REG: rdData_reg <= {2'h0, irqFlag_reg, 5'h00};
				`CTK_OFS_SHDATA: rdData_reg <= {4'h0, result_reg[11:8]};
				`CTK_OFS_CNTLOW: rdData_reg <= result_reg[7:0];
				`CTK_OFS_TCTRL: rdData_reg <= {powerDown_reg, done_reg, slowClk_reg,
					voltSel_reg, timeSel_reg};
				`CTK_OFS_CHSEL: rdData_reg <= {trim_reg, chanSel_reg};
				`CTK_OFS_AUX_CONTROL_ONE: rdData_reg <= {2'h0, start_reg, 5'h00};
				// Unmapped addresses read as zero
				default: rdData_reg <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Status outputs for the analog front end and the core
	assign sfrRdData = rdData_reg;
	assign analogEnable = !powerDown_reg;
	assign padSelect = padSel_reg;
	assign refCapSelect = refSel_reg;
	assign voltSelect = voltSel_reg;
	assign touchClkTick = meas.tick;
	assign convBusy = (state_reg != CTK_IDLE);
	assign touchIrqFlag = irqFlag_reg;
endmodule // ctk_sequencer
`default_nettype wire

// [testbench/ctk_osc_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Sense oscillator seen through the selected electrode
// ----------------------------------------------------------------
module ctk_osc_model (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [19:0] padSelect,
	input wire logic refCapSelect,
	output logic senseOsc
);
	logic [1:0] divReg;
	// Idle pads sit driven, so the line stands still between frames
	always_ff @(posedge ref_clk) begin
		if (srst || (padSelect == 20'h00000 && !refCapSelect)) begin
			divReg <= 2'h0;
			senseOsc <= 1'b0;
		end else if (divReg == (refCapSelect ? 2'h2 : 2'h1)) begin
			divReg <= 2'h0;
			senseOsc <= !senseOsc;
		end else begin
			divReg <= divReg + 2'h1;
		end
	end
endmodule // ctk_osc_model
`default_nettype wire

// [testbench/ctk_sequencer_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module ctk_sequencer_chk #(
	parameter int NUM_CHAN = 20
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] sfrAddr,
	input wire logic sfrWrEn,
	input wire logic [7:0] sfrWrData,
	input wire logic [NUM_CHAN-1:0] padSelect,
	input wire logic refCapSelect,
	input wire logic analogEnable,
	input wire logic touchClkTick,
	input wire logic convBusy,
	input wire logic touchIrqFlag
);
	import ctk_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ----------------------------------------------------------------
	// Decoded software writes
	// ----------------------------------------------------------------
	logic startWr;
	logic stopWr;
	logic flagClrWr;
	assign startWr = sfrWrEn && sfrAddr == 8'hF8 && sfrWrData[5];
	assign stopWr = sfrWrEn && sfrAddr == 8'hF8 && !sfrWrData[5];
	assign flagClrWr = sfrWrEn && sfrAddr == 8'h95 && !sfrWrData[5];
	sequence s_launch;
		startWr && analogEnable && !convBusy;
	endsequence
	sequence s_settle;
		(convBusy && !touchClkTick) [*4];
	endsequence
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	AST_OFF_START: assert property (startWr && !analogEnable && !convBusy |=> !convBusy)
		else $error("start taken while powered down");
	AST_LAUNCH: assert property (s_launch |=> convBusy && !touchIrqFlag)
		else $error("start did not begin conversion or clear flag");
	AST_SETTLE: assert property (s_launch |=> s_settle)
		else $error("settle phase wrong after start");
	AST_PAD: assert property (padSelect != '0 |-> convBusy && $onehot(padSelect))
		else $error("pad select outside conversion or not one-hot");
	AST_REF: assert property (refCapSelect |-> convBusy && padSelect == '0)
		else $error("reference capacitor select wrong");
	AST_TICK: assert property (touchClkTick |-> convBusy)
		else $error("touch clock tick while idle");
	AST_IRQ_SET: assert property ($rose(touchIrqFlag) |-> $fell(convBusy))
		else $error("flag rose without conversion end");
	AST_IRQ_CLR: assert property (flagClrWr && !convBusy |=> !touchIrqFlag)
		else $error("flag not cleared by write");
	AST_ABORT: assert property (stopWr && convBusy |=> ##[0:1] !convBusy)
		else $error("clearing start did not stop conversion");
endmodule // ctk_sequencer_chk
`default_nettype wire

// [testbench/capacitive_touch_key_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module capacitive_touch_key_sequencer_test;
	import ctk_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] sfrAddr = 8'h00;
	logic sfrWrEn = 1'b0;
	logic [7:0] sfrWrData = 8'h00;
	logic sfrRdEn = 1'b0;
	logic [7:0] sfrRdData;
	logic senseOsc;
	logic analogEnable;
	logic [19:0] padSelect;
	logic refCapSelect;
	logic [1:0] voltSelect;
	logic touchClkTick;
	logic convBusy;
	logic touchIrqFlag;
	int fails = 0;
	int num_checks = 0;
	ctk_count_t cntA;
	ctk_count_t cntB;
	ctk_count_t cntC;
	logic [7:0] d;
	// 25 MHz system clock
	always #20 ref_clk = ~ref_clk;
	ctk_sequencer i_dut (.ref_clk(ref_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn),
		.sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .senseOsc(senseOsc),
		.analogEnable(analogEnable), .padSelect(padSelect), .refCapSelect(refCapSelect),
		.voltSelect(voltSelect), .touchClkTick(touchClkTick), .convBusy(convBusy),
		.touchIrqFlag(touchIrqFlag));
	ctk_osc_model i_osc (.ref_clk(ref_clk), .srst(srst), .padSelect(padSelect),
		.refCapSelect(refCapSelect), .senseOsc(senseOsc));
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task summarize;
		if (fails == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task chk(input logic [19:0] seen, input logic [19:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrWrData <= v;
		sfrWrEn <= 1'b1;
		@(posedge ref_clk);
		sfrWrEn <= 1'b0;
	endtask
	// Read data lands at the strobe edge, so sample just after it
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		sfrAddr <= a;
		sfrRdEn <= 1'b1;
		@(posedge ref_clk);
		sfrRdEn <= 1'b0;
		#1 v = sfrRdData;
	endtask
	// One full conversion; also spaces the next start by 50 us
	task conv(input logic [4:0] ch, input logic [7:0] ctl, input logic [2:0] trim,
		output ctk_count_t c);
		int n;
		wr(8'hAD, ctl);
		wr(8'hA7, {trim, ch});
		wr(8'hF8, 8'h20);
		#1;
		chk(convBusy, 1);
		chk(touchIrqFlag, 0);
		chk(padSelect, (ch <= 5'h13) ? 20'h1 << ch : 20'h0);
		chk(refCapSelect, ch == 5'h17);
		repeat (75) @(posedge ref_clk);
		n = 0;
		do begin
			rd(8'hAD, d);
			n++;
		end while (d[6] !== 1'b1 && n < 4000);
		if (d[6] !== 1'b1) begin
			fails++;
			summarize();
		end
		chk(padSelect, 0);
		rd(8'hF8, d);
		chk(d, 8'h00);
		rd(8'h95, d);
		chk(d, 8'h20);
		rd(8'hAA, d);
		chk(d[7:4], 0);
		c[11:8] = d[3:0];
		rd(8'hAC, d);
		c[7:0] = d;
		repeat (1250) @(posedge ref_clk);
		rd(8'hAC, d);
		chk(d, c[7:0]);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
		logic [7:0] ra [8];
		logic [7:0] rv [8];
		ra = '{8'hAD, 8'hA7, 8'h94, 8'h95, 8'hF8, 8'hAA, 8'hAC, 8'h00};
		rv = '{8'hC4, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd(ra[i], d);
			chk(d, rv[i]);
		end
		chk(analogEnable, 0);
	endtask
	// Start while powered down must be ignored
	task t_powerdown;
		wr(8'hF8, 8'h20);
		#1;
		chk(convBusy, 0);
		rd(8'hF8, d);
		chk(d, 8'h00);
	endtask
	// Edge channels, reference channel, time and trim ordering
	task t_counts;
		conv(5'h00, 8'h00, 3'h1, cntA);
		chk(analogEnable, 1);
		chk(cntA != 0, 1);
		conv(5'h13, 8'h00, 3'h1, cntB);
		conv(5'h17, 8'h00, 3'h1, cntC);
		chk(cntC < cntA, 1);
		conv(5'h00, 8'h19, 3'h1, cntB);
		chk(voltSelect, 3);
		chk(cntB > cntA, 1);
		conv(5'h00, 8'h00, 3'h0, cntB);
		conv(5'h00, 8'h00, 3'h7, cntC);
		chk(cntC < cntB, 1);
		// Slow clock halves the tick rate, so the window and count grow
		conv(5'h00, 8'h20, 3'h1, cntB);
		chk(cntB > cntA, 1);
	endtask
	task t_hop;
		wr(8'h94, 8'h40);
		rd(8'h94, d);
		chk(d, 8'h40);
		// Hop shortens the mean tick period and makes trim irrelevant
		conv(5'h05, 8'h00, 3'h0, cntB);
		chk(cntB < cntA, 1);
		conv(5'h05, 8'h00, 3'h7, cntC);
		chk((cntB > cntC) ? (cntB - cntC < 12'h008) : (cntC - cntB < 12'h008), 1);
		wr(8'h94, 8'h00);
	endtask
	// Flag clear by write, then start clears it and an abort keeps the result
	task t_flag_abort;
		wr(8'h95, 8'hDF);
		rd(8'h95, d);
		chk(d, 8'h00);
		conv(5'h02, 8'h00, 3'h1, cntA);
		wr(8'hF8, 8'h20);
		#1;
		chk(touchIrqFlag, 0);
		repeat (100) @(posedge ref_clk);
		wr(8'hF8, 8'h00);
		#1;
		chk(convBusy, 0);
		chk(touchIrqFlag, 0);
		rd(8'hAC, d);
		chk(d, cntA[7:0]);
		rd(8'hAA, d);
		chk(d[3:0], cntA[11:8]);
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		t_reset();
		t_powerdown();
		t_counts();
		t_hop();
		t_flag_abort();
		summarize();
	end
endmodule // capacitive_touch_key_sequencer_test
bind ctk_sequencer ctk_sequencer_chk #(.NUM_CHAN(NUM_CHAN)) i_chk (.ref_clk(ref_clk),
	.srst(srst), .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
	.padSelect(padSelect), .refCapSelect(refCapSelect), .analogEnable(analogEnable),
	.touchClkTick(touchClkTick), .convBusy(convBusy), .touchIrqFlag(touchIrqFlag));
`default_nettype wire
